// ---- logic/status_flags_bank_select.sv ----
// Functional notes
// [R1] Bank select bit clear maps direct addresses to 00h-7Fh, set to 80h-FFh.
// [R2] Watchdog expired flag sets at power-up, on watchdog clear and on sleep.
// [R3] Watchdog expired flag clears on a watchdog timer time-out.
// [R4] Power-down flag sets at power-up and on watchdog clear.
// [R5] Power-down flag clears when the sleep instruction executes.
// [R6] Flag-updating instruction writing status keeps ALU zero, nibble and carry results.
// [R7] Writes to watchdog expired and power-down flags are ignored.
// [R8] In subtraction, carry and nibble carry are inverted borrows.
// [R9] Software keeps the two upper status bits cleared.
// [R10] Zero flag is set when the result is zero, else cleared.
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_cfg.svh"

module status_flags_bank_select (
  input  wire logic                      I_CLK,
  input  wire logic                      I_RST_N,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [7:0]                I_PADDR,
  input  wire logic [31:0]               I_PWDATA,
  output logic [31:0]                    O_PRDATA,
  output logic                           O_PREADY,
  output logic                           O_PSLVERR,
  input  wire logic                      I_WATCHDOG_CLEAR_OP,
  input  wire logic                      I_SLEEP_OP,
  input  wire logic                      I_WATCHDOG_TIMEOUT,
  input  wire logic                      I_CORE_WR,
  input  wire logic [7:0]                I_CORE_WDATA,
  input  wire logic                      I_FLAG_UPD,
  input  wire status_flags_pkg::alu_op_e I_ALU_OP,
  input  wire logic [7:0]                I_ALU_A,
  input  wire logic [7:0]                I_ALU_B,
  input  wire logic [7:0]                I_LOGIC_RESULT,
  input  wire logic [6:0]                I_DIR_ADDR,
  output logic [7:0]                     O_BANK_ADDR,
  output logic [7:0]                     O_STATUS,
  output logic [7:0]                     O_ALU_RESULT,
  output logic                           O_IRQ
);
  import status_flags_pkg::*;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS   = {`SFB_IDX_PROCESSOR_STATUS, 2'b00};
  localparam logic [7:0] ADDR_IRQ_STAT = {`SFB_IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] ADDR_IRQ_MASK = {`SFB_IDX_IRQ_MASK, 2'b00};

  bank_state_s               q, d;
  logic                      setup_ph;
  logic                      access_ph;
  logic                      addr_hit;
  logic                      apb_wr;
  logic [31:0]               read_mux;
  logic [`SFB_EV_COUNT-1:0]  ev_set;
  logic [`SFB_EV_COUNT-1:0]  ev_clr;
  logic [`SFB_EV_COUNT-1:0]  irq_stat;
  logic [7:0]                alu_res;
  logic                      alu_zero;
  logic                      alu_nibble;
  logic                      alu_carry;
  logic                      alu_arith;
  logic                      upper_wr_sw;
  logic                      upper_wr_core;

  assign setup_ph  = I_PSEL && !I_PENABLE;
  assign access_ph = I_PSEL && I_PENABLE;
  assign addr_hit  = (I_PADDR == ADDR_STATUS) || (I_PADDR == ADDR_IRQ_STAT)
                  || (I_PADDR == ADDR_IRQ_MASK);
  assign apb_wr    = access_ph && I_PWRITE;

  always_comb begin
    read_mux = 32'h0000_0000;
    case (I_PADDR)
      ADDR_STATUS:   read_mux[7:0] = q.status;
      ADDR_IRQ_STAT: read_mux[`SFB_EV_COUNT-1:0] = irq_stat;
      ADDR_IRQ_MASK: read_mux[`SFB_EV_COUNT-1:0] = q.irq_mask;
      default:       read_mux = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------
  // Result flag computation
  // --------------------------------------------------------------------
  flag_alu #(
    .W (8)
  ) u_flag_alu (
    .i_op           (I_ALU_OP),
    .i_a            (I_ALU_A),
    .i_b            (I_ALU_B),
    .i_logic_result (I_LOGIC_RESULT),
    .o_result       (alu_res),
    .o_zero         (alu_zero),
    .o_nibble_carry (alu_nibble),
    .o_carry        (alu_carry),
    .o_arith        (alu_arith)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    d = q;
    // Software path; the two hardware-owned flags are never taken
    if (apb_wr && (I_PADDR == ADDR_STATUS)) begin
      d.status[7:5] = I_PWDATA[7:5];
      d.status[2:0] = I_PWDATA[2:0]; // R7
    end
    if (apb_wr && (I_PADDR == ADDR_IRQ_MASK)) begin
      d.irq_mask = I_PWDATA[`SFB_EV_COUNT-1:0];
    end
    // Core write wins over a bus write in the same cycle, for bits 7:5 always and for bits 2:0 only without a flag update
    if (I_CORE_WR) begin
      d.status[7:5] = I_CORE_WDATA[7:5]; // R7
      if (!I_FLAG_UPD) begin
        d.status[2:0] = I_CORE_WDATA[2:0];
      end
    end
    // Flag-updating ALU operations override an explicit zero write; carry and nibble carry only for add and subtract
    if (I_FLAG_UPD && (I_ALU_OP != ALU_NONE)) begin
      d.status[`SFB_BIT_ZERO] = alu_zero; // R6 R10
      if (alu_arith) begin
        d.status[`SFB_BIT_CARRY]        = alu_carry; // R6 R8
        d.status[`SFB_BIT_NIBBLE_CARRY] = alu_nibble; // R8
      end
    end
    // Hardware events; a time-out wins for the expired flag
    if (I_WATCHDOG_CLEAR_OP) begin
      d.status[`SFB_BIT_WATCHDOG_EXPIRED] = 1'b1; // R2
      d.status[`SFB_BIT_POWER_DOWN]       = 1'b1; // R4
    end
    if (I_SLEEP_OP) begin
      d.status[`SFB_BIT_WATCHDOG_EXPIRED] = 1'b1; // R2
      d.status[`SFB_BIT_POWER_DOWN]       = 1'b0; // R5
    end
    if (I_WATCHDOG_TIMEOUT) begin
      d.status[`SFB_BIT_WATCHDOG_EXPIRED] = 1'b0; // R3
    end
    // Read data latched in setup so it is stable through the access
    if (setup_ph) begin
      d.rdata = read_mux;
    end
  end

  // Power-up leaves both hardware flags set
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      q.status   <= `SFB_RST_PROCESSOR_STATUS; // R2 R4
      q.irq_mask <= `SFB_RST_IRQ_MASK;
      q.rdata    <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt events
  // --------------------------------------------------------------------
  // Upper bits should stay clear; a nonzero write is flagged
  assign upper_wr_sw   = apb_wr && (I_PADDR == ADDR_STATUS) && (I_PWDATA[7:6] != 2'b00);
  assign upper_wr_core = I_CORE_WR && (I_CORE_WDATA[7:6] != 2'b00);

  always_comb begin
    ev_set = '0;
    ev_set[`SFB_EV_EXPIRED]  = I_WATCHDOG_TIMEOUT;
    ev_set[`SFB_EV_SLEEP]    = I_SLEEP_OP;
    ev_set[`SFB_EV_RESERVED] = upper_wr_sw || upper_wr_core; // R9
    ev_clr = '0;
    if (apb_wr && (I_PADDR == ADDR_IRQ_STAT)) begin
      ev_clr = I_PWDATA[`SFB_EV_COUNT-1:0];
    end
  end

  for (genvar gi = 0; gi < `SFB_EV_COUNT; gi++) begin : g_irq
    sticky_event u_sticky (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_set   (ev_set[gi]),
      .i_clr   (ev_clr[gi]),
      .o_flag  (irq_stat[gi])
    );
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign O_PREADY     = 1'b1;
  assign O_PSLVERR    = access_ph && !addr_hit;
  assign O_PRDATA     = q.rdata;
  assign O_STATUS     = q.status;
  assign O_ALU_RESULT = alu_res;
  assign O_IRQ        = |(irq_stat & q.irq_mask);

  // Only the bank bit extends the direct address
  assign O_BANK_ADDR  = (q.status[`SFB_BIT_BANK_SELECT] ? `SFB_BANK1_BASE : `SFB_BANK0_BASE)
                      | ({1'b0, I_DIR_ADDR} & `SFB_BANK_OFFSET_MASK); // R1

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_quiet_hw;
    !I_WATCHDOG_CLEAR_OP && !I_SLEEP_OP && !I_WATCHDOG_TIMEOUT;
  endsequence

  sequence s_reserved_write;
    upper_wr_sw || upper_wr_core;
  endsequence

  sequence s_apb_read;
    (setup_ph && !I_PWRITE) ##1 (access_ph && !I_PWRITE && $stable(I_PADDR));
  endsequence

  sequence s_unmapped_write;
    apb_wr && !addr_hit && !I_CORE_WR && !I_FLAG_UPD;
  endsequence

  bank_addr_map_a: assert property ( // R1
    (O_BANK_ADDR[7] == O_STATUS[`SFB_BIT_BANK_SELECT]) && (O_BANK_ADDR[6:0] == I_DIR_ADDR))
    else $error("bank address does not follow bank select");

  clear_sets_expired_a: assert property ( // R2
    (I_WATCHDOG_CLEAR_OP || I_SLEEP_OP) && !I_WATCHDOG_TIMEOUT
    |=> O_STATUS[`SFB_BIT_WATCHDOG_EXPIRED])
    else $error("expired flag not set by clear or sleep");

  timeout_clears_a: assert property ( // R3
    I_WATCHDOG_TIMEOUT |=> !O_STATUS[`SFB_BIT_WATCHDOG_EXPIRED])
    else $error("expired flag not cleared by time-out");

  clear_sets_powerdown_a: assert property ( // R4
    I_WATCHDOG_CLEAR_OP && !I_SLEEP_OP |=> O_STATUS[`SFB_BIT_POWER_DOWN])
    else $error("power-down flag not set by watchdog clear");

  sleep_clears_powerdown_a: assert property ( // R5
    I_SLEEP_OP |=> !O_STATUS[`SFB_BIT_POWER_DOWN])
    else $error("power-down flag not cleared by sleep");

  flag_write_block_a: assert property ( // R6
    I_CORE_WR && I_FLAG_UPD && alu_arith
    |=> O_STATUS[2:0] == {$past(alu_zero), $past(alu_nibble), $past(alu_carry)})
    else $error("explicit write reached result flags");

  hw_flags_hold_a: assert property ( // R7
    s_quiet_hw |=> $stable(O_STATUS[4:3]))
    else $error("hardware-owned flags changed by a write");

  sub_borrow_a: assert property ( // R8
    I_FLAG_UPD && (I_ALU_OP == ALU_SUB)
    |=> O_STATUS[`SFB_BIT_CARRY] == ($past(I_ALU_A) >= $past(I_ALU_B)))
    else $error("carry is not inverted borrow in subtraction");

  zero_flag_a: assert property ( // R10
    I_FLAG_UPD && (I_ALU_OP != ALU_NONE)
    |=> O_STATUS[`SFB_BIT_ZERO] == ($past(alu_res) == 8'h00))
    else $error("zero flag disagrees with result");

  reserved_irq_a: assert property ( // R9
    s_reserved_write |=> irq_stat[`SFB_EV_RESERVED])
    else $error("reserved-bit write not flagged");

  apb_read_data_a: assert property (
    s_apb_read |-> O_PRDATA == $past(read_mux))
    else $error("read data not the value seen at setup");

  irq_level_a: assert property (
    I_SLEEP_OP && q.irq_mask[`SFB_EV_SLEEP] && !apb_wr |=> O_IRQ)
    else $error("unmasked sleep event did not raise the interrupt");

  irq_w1c_a: assert property (
    apb_wr && (I_PADDR == ADDR_IRQ_STAT) && I_PWDATA[`SFB_EV_SLEEP] && !I_SLEEP_OP
    |=> !irq_stat[`SFB_EV_SLEEP])
    else $error("write of one did not clear the sleep event");

  logic_keeps_carry_a: assert property ( // R6
    I_FLAG_UPD && (I_ALU_OP == ALU_LOGIC) && !I_CORE_WR && !apb_wr
    |=> $stable(O_STATUS[1:0]))
    else $error("logic operation changed carry or nibble carry");

  core_status_write_a: assert property (
    I_CORE_WR && !I_FLAG_UPD |=> O_STATUS[2:0] == $past(I_CORE_WDATA[2:0]))
    else $error("core write did not reach the result flags");

  // --------------------------------------------------------------------
  // Bus-side checks
  // --------------------------------------------------------------------
  // Unmapped writes must leave every status bit alone
  unmapped_ignore_a: assert property (
    s_unmapped_write ##0 s_quiet_hw |=> $stable(O_STATUS))
    else $error("write to an unmapped address changed status");

  sw_status_write_a: assert property (
    apb_wr && (I_PADDR == ADDR_STATUS) && !I_CORE_WR
    |=> O_STATUS[7:5] == $past(I_PWDATA[7:5]))
    else $error("bus write did not reach the upper status bits");

  read_data_hold_a: assert property (
    !setup_ph |=> $stable(O_PRDATA))
    else $error("read data changed outside a setup cycle");

endmodule : status_flags_bank_select

`default_nettype wire

// ---- logic/status_flags_cfg.svh ----
`ifndef STATUS_FLAGS_CFG_SVH
`define STATUS_FLAGS_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SFB_IDX_PROCESSOR_STATUS 6'h03
`define SFB_IDX_IRQ_STATUS       6'h04
`define SFB_IDX_IRQ_MASK         6'h05

// ----------------------------------------------------------------------
// Processor status field positions
// ----------------------------------------------------------------------
`define SFB_BIT_CARRY            0
`define SFB_BIT_NIBBLE_CARRY     1
`define SFB_BIT_ZERO             2
`define SFB_BIT_POWER_DOWN       3
`define SFB_BIT_WATCHDOG_EXPIRED 4
`define SFB_BIT_BANK_SELECT      5
`define SFB_BIT_UPPER_BANK       6
`define SFB_BIT_INDIRECT_BANK    7

// ----------------------------------------------------------------------
// Reset values and bank bases
// ----------------------------------------------------------------------
`define SFB_RST_PROCESSOR_STATUS 8'h18
`define SFB_RST_IRQ_MASK         3'h0
`define SFB_BANK0_BASE           8'h00
`define SFB_BANK1_BASE           8'h80
`define SFB_BANK_OFFSET_MASK     8'h7F

// ----------------------------------------------------------------------
// Interrupt event positions
// ----------------------------------------------------------------------
`define SFB_EV_EXPIRED           0
`define SFB_EV_SLEEP             1
`define SFB_EV_RESERVED          2
`define SFB_EV_COUNT             3

`endif

// ---- logic/status_flags_pkg.sv ----
`default_nettype none
`include "status_flags_cfg.svh"

package status_flags_pkg;

  typedef enum logic [1:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_SUB,
    ALU_LOGIC
  } alu_op_e;

  typedef struct packed {
    logic [7:0]                 status;
    logic [`SFB_EV_COUNT-1:0]   irq_mask;
    logic [31:0]                rdata;
  } bank_state_s;

  typedef struct packed {
    logic flag;
  } sticky_s;

endpackage : status_flags_pkg

`default_nettype wire

// ---- logic/flag_alu.sv ----
`timescale 1ns/1ps
`default_nettype none

module flag_alu #(
  parameter int W = 8
) (
  input  wire status_flags_pkg::alu_op_e i_op,
  input  wire logic [W-1:0]              i_a,
  input  wire logic [W-1:0]              i_b,
  input  wire logic [W-1:0]              i_logic_result,
  output logic [W-1:0]                   o_result,
  output logic                           o_zero,
  output logic                           o_nibble_carry,
  output logic                           o_carry,
  output logic                           o_arith
);
  import status_flags_pkg::*;

  logic [W:0]   full_sum;
  logic [4:0]   low_sum;
  logic [W-1:0] b_eff;
  logic         cin;

  // Subtract as a + ~b + 1, so carry out is the inverted borrow
  always_comb begin
    cin      = (i_op == ALU_SUB);
    b_eff    = cin ? ~i_b : i_b;
    full_sum = {1'b0, i_a} + {1'b0, b_eff} + {{W{1'b0}}, cin};
    low_sum  = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    o_arith  = (i_op == ALU_ADD) || (i_op == ALU_SUB);
    o_result = (i_op == ALU_LOGIC) ? i_logic_result : full_sum[W-1:0];
    o_zero         = (o_result == '0);
    o_carry        = full_sum[W];
    o_nibble_carry = low_sum[4];
  end

endmodule : flag_alu

`default_nettype wire

// ---- logic/sticky_event.sv ----
`timescale 1ns/1ps
`default_nettype none

module sticky_event (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);
  import status_flags_pkg::*;

  sticky_s q, d;

  // Set wins over a clear in the same cycle
  always_comb begin
    d = q;
    if (i_clr) begin
      d.flag = 1'b0;
    end
    if (i_set) begin
      d.flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_flag = q.flag;

endmodule : sticky_event

`default_nettype wire

// ---- testbench/status_flags_bank_select_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_cfg.svh"

module status_flags_bank_select_tb;
  import status_flags_pkg::*;

  localparam logic [7:0] A_ST = {`SFB_IDX_PROCESSOR_STATUS, 2'b00};
  localparam logic [7:0] A_IS = {`SFB_IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_IM = {`SFB_IDX_IRQ_MASK, 2'b00};

  logic        clk = 1'b0;
  logic        rst_n, psel, pen, pwr, wdc, slp, wdt, cwr, fupd, prdy, perr, irq, err;
  logic [7:0]  paddr, cwd, a, b, lres, bank, st, res;
  logic [31:0] pwd, prd, rd;
  logic [6:0]  dir;
  alu_op_e     op;
  int          n_errors = 0;
  int          num_checks = 0;

  always #12.5 clk = ~clk;

  status_flags_bank_select i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .I_WATCHDOG_CLEAR_OP(wdc), .I_SLEEP_OP(slp), .I_WATCHDOG_TIMEOUT(wdt),
    .I_CORE_WR(cwr), .I_CORE_WDATA(cwd), .I_FLAG_UPD(fupd), .I_ALU_OP(op),
    .I_ALU_A(a), .I_ALU_B(b), .I_LOGIC_RESULT(lres), .I_DIR_ADDR(dir),
    .O_BANK_ADDR(bank), .O_STATUS(st), .O_ALU_RESULT(res), .O_IRQ(irq)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // Holds the request until pready is seen; checks that it comes after one access cycle
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    pwr   <= w;
    paddr <= ad;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1);
    rd   = prd;
    err  = perr;
    chk("pready wait", 32'h1, 32'(n));
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // One-cycle core pulse {clear, sleep, timeout, write, flag update}
  task automatic core(input logic [4:0] v, input logic [7:0] d);
    @(posedge clk);
    {wdc, slp, wdt, cwr, fupd} <= v;
    cwd <= d;
    @(posedge clk);
    {wdc, slp, wdt, cwr, fupd} <= 5'h00;
    @(negedge clk);
  endtask : core

  task automatic alu(input alu_op_e o, input logic [7:0] x, y, r, input logic [2:0] f);
    @(posedge clk);
    op   <= o;
    a    <= x;
    b    <= y;
    lres <= y;
    core(5'h01, 8'h00);
    chk("result", 32'(r), 32'(res));
    chk("flags", 32'(f), 32'(st[2:0]));
  endtask : alu

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, wdc, slp, wdt, cwr, fupd} = 8'h00;
    {paddr, cwd, a, b, lres} = 40'h0;
    pwd = 32'h0;
    dir = 7'h05;
    op  = ALU_NONE;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("status reset", 32'h18, 32'(st));
    chk("irq reset", 32'h0, 32'(irq));
    apb(1'b0, A_ST, 32'h0);
    chk("status read", 32'h18, rd);
    chk("status err", 32'h0, 32'(err));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h40, 32'hFF);
    @(negedge clk);
    chk("unmapped wr err", 32'h1, 32'(err));
    chk("unmapped wr", 32'h18, 32'(st));
    apb(1'b1, A_ST, 32'h27);
    @(negedge clk);
    chk("status write", 32'h3F, 32'(st));
    chk("bank1 addr", 32'h85, 32'(bank));
    apb(1'b1, A_ST, 32'h00);
    dir <= 7'h7F;
    @(negedge clk);
    chk("status clear", 32'h18, 32'(st));
    chk("bank0 addr", 32'h7F, 32'(bank));
    core(5'h08, 8'h00);
    chk("after sleep", 32'h10, 32'(st));
    core(5'h02, 8'h08);
    chk("core wr pd", 32'h10, 32'(st));
    core(5'h10, 8'h00);
    chk("after clear", 32'h18, 32'(st));
    core(5'h04, 8'h00);
    chk("after timeout", 32'h08, 32'(st));
    core(5'h08, 8'h00);
    chk("sleep again", 32'h10, 32'(st));
    @(posedge clk);
    op  <= ALU_ADD;
    a   <= 8'hFF;
    b   <= 8'h01;
    dir <= 7'h00;
    core(5'h03, 8'h20);
    chk("flags over write", 32'h37, 32'(st));
    chk("bank1 base", 32'h80, 32'(bank));
    alu(ALU_ADD, 8'h08, 8'h08, 8'h10, 3'b010);
    alu(ALU_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
    alu(ALU_SUB, 8'h00, 8'h01, 8'hFF, 3'b000);
    alu(ALU_SUB, 8'h10, 8'h01, 8'h0F, 3'b001);
    alu(ALU_LOGIC, 8'h00, 8'h00, 8'h00, 3'b101);
    alu(ALU_LOGIC, 8'h00, 8'h5A, 8'h5A, 3'b001);
    alu(ALU_NONE, 8'h00, 8'h00, 8'h00, 3'b001);
    // Events so far: timeout and sleep, all masked off
    apb(1'b0, A_IS, 32'h0);
    chk("irq status", 32'h3, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, A_IM, 32'h2);
    @(negedge clk);
    chk("irq unmasked", 32'h1, 32'(irq));
    apb(1'b1, A_IS, 32'h2);
    @(negedge clk);
    chk("irq w1c", 32'h0, 32'(irq));
    apb(1'b1, A_IM, 32'h7);
    @(negedge clk);
    chk("irq bit0", 32'h1, 32'(irq));
    apb(1'b1, A_IS, 32'h1);
    apb(1'b0, A_IS, 32'h0);
    chk("irq cleared", 32'h0, rd);
    apb(1'b1, A_ST, 32'h40);
    apb(1'b0, A_IS, 32'h0);
    chk("reserved write irq", 32'h4, rd);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b0, A_IM, 32'h0);
    chk("mask read", 32'h7, rd);
    apb(1'b1, A_IS, 32'h4);
    @(negedge clk);
    chk("irq idle", 32'h0, 32'(irq));
    core(5'h08, 8'h00);
    chk("sleep irq", 32'h1, 32'(irq));
    core(5'h02, 8'h80);
    apb(1'b0, A_IS, 32'h0);
    chk("core reserved irq", 32'h6, rd);
    summarize();
  end

  initial begin
    #50000;
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    summarize();
  end

endmodule : status_flags_bank_select_tb

`default_nettype wire
